// *** wsi_pkg.sv ***
// package: register map, field positions, reset values, rates for the wake/irq config block
package wsi_pkg;
	// register byte offsets on apb
	localparam logic [7:0] WSI_OFF_CFG = 8'h00;
	localparam logic [7:0] WSI_OFF_STATUS = 8'h04;
	localparam logic [7:0] WSI_OFF_CTRL = 8'h08;
	localparam logic [7:0] WSI_OFF_FILL = 8'h0c;
	localparam logic [7:0] WSI_OFF_DATA = 8'h10;
	// config register fields
	localparam int WSI_CFG_GATE = 7;
	localparam int WSI_CFG_TRANS = 6;
	localparam int WSI_CFG_ORIENT = 5;
	localparam int WSI_CFG_PULSE = 4;
	localparam int WSI_CFG_FFMT = 3;
	localparam int WSI_CFG_LEVEL = 1;
	localparam int WSI_CFG_DRIVE = 0;
	localparam logic [7:0] WSI_CFG_RESET = 8'h00;
	localparam logic [7:0] WSI_CFG_MASK = 8'hfb;
	// status register fields
	localparam int WSI_ST_GATE_ERR = 7;
	localparam int WSI_ST_GATED = 2;
	localparam int WSI_ST_MODE_LO = 0;
	// control register fields
	localparam int WSI_CTRL_DR_LO = 0;
	localparam int WSI_CTRL_SLR_LO = 3;
	localparam logic [4:0] WSI_CTRL_RESET = 5'h00;
	// sample buffer
	localparam int WSI_DEPTH = 32;
	localparam int WSI_PTR_W = 5;
	localparam int WSI_CNT_W = 6;
	localparam int WSI_DATA_W = 16;
	// sample period in pclk cycles per data rate; index 0..7 = 800 Hz .. 1.56 Hz
	localparam int WSI_CLK_NS = 50;
	localparam int WSI_RATE_W = 24;
	localparam logic [WSI_RATE_W-1:0] WSI_RATE_CYC [8] = '{
		WSI_RATE_W'(1250000 / WSI_CLK_NS), WSI_RATE_W'(2500000 / WSI_CLK_NS),
		WSI_RATE_W'(5000000 / WSI_CLK_NS), WSI_RATE_W'(10000000 / WSI_CLK_NS),
		WSI_RATE_W'(20000000 / WSI_CLK_NS), WSI_RATE_W'(80000000 / WSI_CLK_NS),
		WSI_RATE_W'(160000000 / WSI_CLK_NS), WSI_RATE_W'(640000000 / WSI_CLK_NS)};
	// sleep rate field 0..3 maps to data-rate index of 50, 12.5, 6.25, 1.56 Hz
	localparam logic [2:0] WSI_SLEEP_IDX [4] = '{3'h4, 3'h5, 3'h6, 3'h7};
	// power modes
	typedef enum logic [1:0] {
		WSI_MODE_STBY = 2'b00,
		WSI_MODE_WAKE = 2'b01,
		WSI_MODE_SLEEP = 2'b10
	} wsi_mode_t;
endpackage

// *** wsi_rate_tick.sv ***
// sample-rate divider: one-cycle tick per selected sample period
`timescale 1ns/1ps
module wsi_rate_tick
	import wsi_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [WSI_RATE_W-1:0] period,
	// tick
	output logic tick
);
	typedef struct packed {
		logic [WSI_RATE_W-1:0] cnt;
		logic tick;
	} wsi_tick_st_t;
	wsi_tick_st_t st_r, st_nxt;
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!run) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt + 1'b1 >= period) begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign tick = st_r.tick;
endmodule

// *** wsi_irq_pad.sv ***
// interrupt pad: polarity and push-pull/open-drain drive, registered
`timescale 1ns/1ps
module wsi_irq_pad (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// config and event
	input wire logic irq,
	input wire logic level_high,
	input wire logic open_drain,
	// pad
	output logic pad_o,
	output logic pad_oe
);
	typedef struct packed {
		logic o;
		logic oe;
	} wsi_pad_st_t;
	wsi_pad_st_t st_r, st_nxt;
	logic lvl;
	always_comb begin
		lvl = level_high ? irq : ~irq;
		st_nxt.o = lvl;
		// open drain only pulls to the non-idle level when asserted
		st_nxt.oe = open_drain ? irq : 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= 2'b11;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign pad_o = st_r.o;
	assign pad_oe = st_r.oe;
endmodule

// *** wsi_wake_irq.sv ***
// wake-source and interrupt pin config with gated sample buffer, apb slave
`timescale 1ns/1ps
// Behaviour
// - with the gate bit set, any wake/sleep transition blocks new samples until the buffer is empty.
// - while gated, stored samples stay unchanged and arriving samples are discarded.
// - with the gate bit set, a sample arriving into an unemptied gated buffer sets the gate error.
// - the gate error stays set as long as the buffer remains unemptied.
// - the transient wake-source bit lets the transient event wake the system from sleep.
// - the orientation wake-source bit lets the orientation event wake the system from sleep.
// - the pulse wake-source bit lets the pulse event wake the system from sleep.
// - the freefall/motion wake-source bit lets that event wake the system from sleep.
// - the level-select bit makes interrupts active low at 0 and active high at 1.
// - the drive-select bit makes the interrupt pins push-pull at 0 and open-drain at 1.
// - the drive-select bit resets to 0, push-pull.
// - in sleep, the sample rate follows the sleep rate field instead of the data rate.
module wsi_wake_irq
	import wsi_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// system mode and samples
	input wire logic active,
	input wire logic sleep_enter,
	input wire logic [WSI_DATA_W-1:0] sample,
	// detector events
	input wire logic ev_transient,
	input wire logic ev_orient,
	input wire logic ev_pulse,
	input wire logic ev_ffmt,
	input wire logic irq1,
	input wire logic irq2,
	// outputs
	output logic wake_req,
	output logic sample_tick,
	output logic int1_o,
	output logic int1_oe,
	output logic int2_o,
	output logic int2_oe
);
	typedef struct packed {
		logic [7:0] cfg;
		logic [4:0] ctrl;
		wsi_mode_t mode;
		logic gated;
		logic gate_err;
		logic [WSI_PTR_W-1:0] wr_ptr;
		logic [WSI_PTR_W-1:0] rd_ptr;
		logic [WSI_CNT_W-1:0] fill;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic wake_req;
		logic tick;
	} wsi_st_t;
	wsi_st_t st_r, st_nxt;
	logic [WSI_DATA_W-1:0] mem [WSI_DEPTH];
	logic tick;
	logic [2:0] rate_idx;
	logic acc;
	logic wr_en;
	logic rd_pop;
	logic push;
	logic wake_ev;
	logic trans;
	wsi_mode_t mode_next;

	// sleep mode overrides the data rate with the sleep rate field
	always_comb begin
		if (st_r.mode == WSI_MODE_SLEEP) begin
			rate_idx = WSI_SLEEP_IDX[st_r.ctrl[WSI_CTRL_SLR_LO +: 2]];
		end else begin
			rate_idx = st_r.ctrl[WSI_CTRL_DR_LO +: 3];
		end
	end

	wsi_rate_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(active),
		.period(WSI_RATE_CYC[rate_idx]),
		.tick(tick)
	);

	// only enabled sources may wake from sleep; others are ignored there
	always_comb begin
		wake_ev = (st_r.cfg[WSI_CFG_TRANS] & ev_transient)
			| (st_r.cfg[WSI_CFG_ORIENT] & ev_orient)
			| (st_r.cfg[WSI_CFG_PULSE] & ev_pulse)
			| (st_r.cfg[WSI_CFG_FFMT] & ev_ffmt);
	end

	always_comb begin
		acc = psel & penable & ~st_r.pready;
		wr_en = acc & pwrite;
		rd_pop = acc & ~pwrite & (paddr == WSI_OFF_DATA) & (st_r.fill != '0);
		case (st_r.mode)
			WSI_MODE_STBY: mode_next = active ? WSI_MODE_WAKE : WSI_MODE_STBY;
			WSI_MODE_WAKE: begin
				if (!active) begin
					mode_next = WSI_MODE_STBY;
				end else begin
					mode_next = sleep_enter ? WSI_MODE_SLEEP : WSI_MODE_WAKE;
				end
			end
			WSI_MODE_SLEEP: begin
				if (!active) begin
					mode_next = WSI_MODE_STBY;
				end else begin
					mode_next = wake_ev ? WSI_MODE_WAKE : WSI_MODE_SLEEP;
				end
			end
			default: mode_next = WSI_MODE_STBY;
		endcase
		trans = ((st_r.mode == WSI_MODE_WAKE) && (mode_next == WSI_MODE_SLEEP))
			|| ((st_r.mode == WSI_MODE_SLEEP) && (mode_next == WSI_MODE_WAKE));
		// gated buffer drops arriving samples; stored ones stay put
		push = tick & ~st_r.gated & (st_r.fill != WSI_CNT_W'(WSI_DEPTH));
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = acc;
		st_nxt.pslverr = 1'b0;
		st_nxt.tick = tick;
		st_nxt.mode = mode_next;
		st_nxt.wake_req = (st_r.mode == WSI_MODE_SLEEP) & wake_ev;
		if (wr_en) begin
			case (paddr)
				WSI_OFF_CFG: st_nxt.cfg = pwdata[7:0] & WSI_CFG_MASK;
				WSI_OFF_CTRL: st_nxt.ctrl = pwdata[4:0];
				WSI_OFF_STATUS, WSI_OFF_FILL, WSI_OFF_DATA: st_nxt.pslverr = 1'b0;
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		if (acc && !pwrite) begin
			st_nxt.prdata = '0;
			case (paddr)
				WSI_OFF_CFG: st_nxt.prdata[7:0] = st_r.cfg;
				WSI_OFF_STATUS: begin
					st_nxt.prdata[WSI_ST_GATE_ERR] = st_r.gate_err;
					st_nxt.prdata[WSI_ST_GATED] = st_r.gated;
					st_nxt.prdata[WSI_ST_MODE_LO +: 2] = st_r.mode;
				end
				WSI_OFF_CTRL: st_nxt.prdata[4:0] = st_r.ctrl;
				WSI_OFF_FILL: st_nxt.prdata[WSI_CNT_W-1:0] = st_r.fill;
				WSI_OFF_DATA: begin
					if (st_r.fill != '0) begin
						st_nxt.prdata[WSI_DATA_W-1:0] = mem[st_r.rd_ptr];
					end
				end
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		if (push) begin
			st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
		end
		if (rd_pop) begin
			st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
		end
		st_nxt.fill = st_r.fill + WSI_CNT_W'(push) - WSI_CNT_W'(rd_pop);
		if (st_r.gated && (st_nxt.fill == '0)) begin
			// emptied: release gate and error together
			st_nxt.gated = 1'b0;
			st_nxt.gate_err = 1'b0;
		end else if (st_r.gated && tick) begin
			st_nxt.gate_err = 1'b1;
		end
		// a transition with samples still stored closes the gate
		if (st_r.cfg[WSI_CFG_GATE] && trans && (st_nxt.fill != '0)) begin
			st_nxt.gated = 1'b1;
		end
	end

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[st_r.wr_ptr] <= sample;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.cfg <= WSI_CFG_RESET;
			st_r.ctrl <= WSI_CTRL_RESET;
			st_r.mode <= WSI_MODE_STBY;
		end else begin
			st_r <= st_nxt;
		end
	end

	wsi_irq_pad u_pad1 (
		.pclk(pclk),
		.presetn(presetn),
		.irq(irq1),
		.level_high(st_r.cfg[WSI_CFG_LEVEL]),
		.open_drain(st_r.cfg[WSI_CFG_DRIVE]),
		.pad_o(int1_o),
		.pad_oe(int1_oe)
	);

	wsi_irq_pad u_pad2 (
		.pclk(pclk),
		.presetn(presetn),
		.irq(irq2),
		.level_high(st_r.cfg[WSI_CFG_LEVEL]),
		.open_drain(st_r.cfg[WSI_CFG_DRIVE]),
		.pad_o(int2_o),
		.pad_oe(int2_oe)
	);

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign wake_req = st_r.wake_req;
	assign sample_tick = st_r.tick;
endmodule

// *** wsi_wake_irq_checker.sv ***
// checker: apb, pad and tick relations
`timescale 1ns/1ps
module wsi_wake_irq_checker
	import wsi_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pad and tick
	input wire logic irq1,
	input wire logic sample_tick,
	input wire logic int1_o,
	input wire logic int1_oe
);
	logic [7:0] cfg_r;
	logic map;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign map = paddr inside {WSI_OFF_CFG, WSI_OFF_STATUS, WSI_OFF_CTRL, WSI_OFF_FILL, WSI_OFF_DATA};
	// shadow of the config word, so pad checks need no internal probe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_r <= 8'h00;
		else if (psel && penable && !pready && pwrite && paddr == WSI_OFF_CFG)
			cfg_r <= pwdata[7:0] & WSI_CFG_MASK;
	end
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held");
	a_err_unmapped: assert property (pready && !map |-> pslverr && prdata == 32'h0) else $error("unmap");
	a_err_mapped: assert property (pready && map |-> !pslverr) else $error("bad err");
	a_cfg_read: assert property (pready && !pwrite && paddr == WSI_OFF_CFG
		|-> prdata == {24'h0, cfg_r}) else $error("cfg read");
	a_pad_level: assert property (1'b1 |=> int1_o ==
		($past(cfg_r[WSI_CFG_LEVEL]) ? $past(irq1) : !$past(irq1))) else $error("level");
	a_pad_drive: assert property (1'b1 |=> int1_oe ==
		($past(cfg_r[WSI_CFG_DRIVE]) ? $past(irq1) : 1'b1)) else $error("drive");
	a_tick_single: assert property (sample_tick |=> !sample_tick) else $error("tick");
endmodule
bind wsi_wake_irq wsi_wake_irq_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq1(irq1), .sample_tick(sample_tick),
	.int1_o(int1_o), .int1_oe(int1_oe));

// *** wsi_irq_line.sv ***
// host interrupt line shared by both pads
`timescale 1ns/1ps
module wsi_irq_line (
	// pads
	input wire logic o1,
	input wire logic oe1,
	input wire logic o2,
	input wire logic oe2,
	// line seen by the host
	output logic line
);
	// pulled up; any enabled low driver wins
	assign line = !((oe1 && !o1) || (oe2 && !o2));
endmodule

// *** tb_top.sv ***
// testbench: register, pad, wake and gate tests
`timescale 1ns/1ps
module tb_top
	import wsi_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic active = 1'b0, sleep_enter = 1'b0, irq1 = 1'b0, irq2 = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] sample = 16'h1234;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, wake_req, sample_tick, int1_o, int1_oe, int2_o, int2_oe, line;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int wakes = 0;
	wsi_wake_irq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .active(active), .sleep_enter(sleep_enter), .sample(sample),
		.ev_transient(ev[3]), .ev_orient(ev[2]), .ev_pulse(ev[1]), .ev_ffmt(ev[0]),
		.irq1(irq1), .irq2(irq2), .wake_req(wake_req), .sample_tick(sample_tick),
		.int1_o(int1_o), .int1_oe(int1_oe), .int2_o(int2_o), .int2_oe(int2_oe));
	wsi_irq_line i_line (.o1(int1_o), .oe1(int1_oe), .o2(int2_o), .oe2(int2_oe), .line(line));
	always #25 pclk = ~pclk;
	// two sample periods plus margin
	always @(posedge pclk) begin
		cyc++;
		if (wake_req === 1'b1)
			wakes++;
		if (cyc == 90000) begin
			miscompares++;
			results();
		end
	end
	task results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task sleep_pulse();
		sleep_enter <= 1'b1;
		@(posedge pclk);
		sleep_enter <= 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b0, WSI_OFF_CFG, 32'h0);
		chk("cfg", 32'h0, rd);
		chk("idle pad", 32'h3, {30'h0, int1_o, int1_oe});
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, WSI_OFF_CFG, 32'(i[1:0]));
			irq1 <= i[2];
			irq2 <= !i[2];
			repeat (2) @(posedge pclk);
			chk("int1", {30'h0, i[1] ~^ i[2], !i[0] || i[2]}, {30'h0, int1_o, int1_oe});
			chk("int2", {30'h0, i[1] ^ i[2], !i[0] || !i[2]}, {30'h0, int2_o, int2_oe});
			chk("line", {31'h0, i[1] & i[0]}, {31'h0, line});
		end
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		active <= 1'b1;
		for (int b = 0; b < 4; b++) begin
			bus(1'b1, WSI_OFF_CFG, 32'h0);
			sleep_pulse();
			ev[b] <= 1'b1;
			wakes = 0;
			repeat (4) @(posedge pclk);
			chk("masked", 32'h0, wakes);
			bus(1'b1, WSI_OFF_CFG, 32'h8 << b);
			repeat (4) @(posedge pclk);
			ev[b] <= 1'b0;
			chk("wake", 32'h1, wakes);
		end
		bus(1'b1, WSI_OFF_CFG, 32'hc0);
		do @(posedge pclk); while (sample_tick !== 1'b1);
		sample <= 16'h5678;
		sleep_pulse();
		bus(1'b0, WSI_OFF_STATUS, 32'h0);
		chk("gated", 32'h6, rd);
		ev[3] <= 1'b1;
		repeat (4) @(posedge pclk);
		ev[3] <= 1'b0;
		do @(posedge pclk); while (sample_tick !== 1'b1);
		bus(1'b0, WSI_OFF_STATUS, 32'h0);
		chk("gate error", 32'h85, rd);
		bus(1'b0, WSI_OFF_FILL, 32'h0);
		chk("fill", 32'h1, rd);
		bus(1'b0, WSI_OFF_DATA, 32'h0);
		chk("kept", 32'h1234, rd);
		bus(1'b0, WSI_OFF_STATUS, 32'h0);
		chk("released", 32'h1, rd);
		results();
	end
endmodule
